// ==== rtl/carf_consts.vh ====
`ifndef CARF_CONSTS_VH
`define CARF_CONSTS_VH
// ==========================================================
// special register numbers
`define CARF_SPR_PTD       10'h019
`define CARF_SPR_SRR_FIRST 10'h01a
`define CARF_SPR_SRR_SEC   10'h01b
`define CARF_SPR_OSS_BASE  10'h110
`define CARF_SPR_EXT_ACC   10'h11a
`define CARF_SPR_VERSION   10'h11f
`define CARF_SPR_BAT_BASE  10'h210
`define CARF_SPR_PROC_TAG  10'h3ff
// encoding bit 0 of a special register number, as a number bit
`define CARF_SPR_ENC_BIT0  4
// ==========================================================
// machine state fields
`define CARF_MSR_PR_BIT    14
`define CARF_MSR_RESET     32'h0000_0000
// ==========================================================
// float status: sticky exception bits (bits 0-12, 21-23 msb first)
`define CARF_FSC_STICKY    32'hfff8_0700
`define CARF_FSC_RN_LSB    0
`define CARF_FSC_RESET     32'h0000_0000
// ==========================================================
// identity values (arbitrary, not any real part)
`define CARF_VERSION_VAL   32'h0001_0001
`define CARF_PROC_TAG_RST  4'h0
`endif

// ==== rtl/carf_fp_convert.v ====
`timescale 1ns/1ps
// ==========================================================
// float format conversion and single-precision rounding
module carf_fp_convert (
  // memory side
  input  wire [31:0] memSingle,
  input  wire [63:0] regDouble,
  // arithmetic result and rounding mode
  input  wire [63:0] arithDouble,
  input  wire [1:0]  roundMode,
  // results
  output reg  [63:0] singleAsDouble,
  output reg  [31:0] doubleAsSingle,
  output reg  [63:0] roundedSingle
);

  reg [4:0]  msbPos;
  reg [52:0] normFrac;
  reg [10:0] dExp;
  reg [4:0]  dShift;
  reg [10:0] dDiff;
  reg [23:0] denFrac;
  reg        guardBit;
  reg        stickyBit;
  reg        roundUp;
  reg [33:0] roundSum;
  integer    i;

  // single to double on load, exact
  always @* begin
    msbPos   = 5'h00;
    normFrac = 53'h0;
    for (i = 0; i < 23; i = i + 1) begin
      if (memSingle[i]) begin
        msbPos = i[4:0];
      end
    end
    if (memSingle[30:23] == 8'hff) begin
      singleAsDouble = {memSingle[31], 11'h7ff, memSingle[22:0], 29'h0};
    end else if (memSingle[30:0] == 31'h0) begin
      singleAsDouble = {memSingle[31], 63'h0};
    end else if (memSingle[30:23] == 8'h00) begin
      normFrac = {1'b0, memSingle[22:0], 29'h0} << (5'd23 - msbPos);
      singleAsDouble = {memSingle[31], 11'd874 + {6'h00, msbPos},
                        normFrac[51:0]};
    end else begin
      singleAsDouble = {memSingle[31], {3'h0, memSingle[30:23]} + 11'd896,
                        memSingle[22:0], 29'h0};
    end
  end

  // double to single on store
  always @* begin
    dExp    = regDouble[62:52];
    dShift  = 5'h00;
    dDiff   = 11'h000;
    denFrac = 24'h0;
    if (dExp >= 11'd897 || dExp == 11'h000 || dExp == 11'h7ff ||
        dExp < 11'd874) begin
      doubleAsSingle = {regDouble[63:62], regDouble[58:29]};
    end else begin
      dDiff   = 11'd897 - dExp;
      dShift  = dDiff[4:0];      // only 1 to 23 reach this branch
      denFrac = {1'b1, regDouble[51:29]} >> dShift;
      doubleAsSingle = {regDouble[63], 8'h00, denFrac[22:0]};
    end
  end

  // round to single precision, kept in double form
  always @* begin
    guardBit  = arithDouble[28];
    stickyBit = |arithDouble[27:0];
    case (roundMode)
      2'b00:   roundUp = guardBit & (stickyBit | arithDouble[29]);
      2'b01:   roundUp = 1'b0;
      2'b10:   roundUp = ~arithDouble[63] & (guardBit | stickyBit);
      2'b11:   roundUp = arithDouble[63] & (guardBit | stickyBit);
      default: roundUp = 1'b0;
    endcase
    roundSum = {arithDouble[62:29]} + {33'h0, roundUp};
    if (arithDouble[62:52] == 11'h7ff) begin
      roundedSingle = arithDouble;
    end else begin
      roundedSingle = {arithDouble[63], roundSum[33:0], 29'h0};
    end
  end

endmodule // carf_fp_convert

// ==== rtl/carf_reg_file.v ====
`timescale 1ns/1ps
`include "carf_consts.vh"
// What this block does
// - thirty-two 32-bit integer registers addressed by operand fields
// - hard reset clears every integer register
// - thirty-two 64-bit float registers as float operands
// - hard reset clears every float register
// - unknown special register: exception if encoding bit 0 set, else no-op
// - any exception enters supervisor mode; privilege bit shows the level
// - supervisor code reaches every register user code reaches
// - first save register takes address on exception, gives the return target on return
// - second save register takes status on exception, restores on return
// - read-only version register copied by a special-register read
// - processor tag register holds a four-bit tag
// - eight block translation registers as four upper/lower pairs
// - external access register gates external control word transfers
// - four operating-system scratch registers with no side effects
// - page table descriptor register feeds address translation
// - float status and condition update only at final writeback
// - double loads and stores move 64 bits unchanged
// - single load converts to the equal double value
// - single store converts to the equal single value
// - unrepresentable results are rounded and stored as double
// - float results go to float registers, read as double format
// - privilege bit in machine state decides reachable registers
module carf_reg_file (
  // clock and reset
  input  wire        core_clk,
  input  wire        srst,
  // integer read and write ports
  input  wire [4:0]  intRdSelA,
  input  wire [4:0]  intRdSelB,
  input  wire [4:0]  intRdSelC,
  input  wire        intWrEn,
  input  wire [4:0]  intWrSel,
  input  wire [31:0] intWrData,
  output reg  [31:0] intRdDataA,
  output reg  [31:0] intRdDataB,
  output reg  [31:0] intRdDataC,
  // float read and arithmetic write ports
  input  wire [4:0]  fpRdSelA,
  input  wire [4:0]  fpRdSelB,
  input  wire [4:0]  fpRdSelC,
  input  wire        fpWbEn,
  input  wire [4:0]  fpWbSel,
  input  wire [63:0] fpWbData,
  input  wire        fpWbSingle,
  input  wire [31:0] fpWbStatus,
  input  wire        fpWbCrEn,
  output reg  [63:0] fpRdDataA,
  output reg  [63:0] fpRdDataB,
  output reg  [63:0] fpRdDataC,
  output reg  [31:0] floatStatusControl,
  output reg  [3:0]  fpCondField,
  // float load and store
  input  wire        fpLoadEn,
  input  wire        fpLoadSingle,
  input  wire [4:0]  fpLoadSel,
  input  wire [63:0] fpLoadData,
  input  wire        fpStoreEn,
  input  wire        fpStoreSingle,
  input  wire [4:0]  fpStoreSel,
  output reg  [63:0] fpStoreData,
  output reg         fpStoreValid,
  // special register moves
  input  wire        sprEn,
  input  wire        sprWrite,
  input  wire [9:0]  sprNum,
  input  wire [31:0] sprWrData,
  output reg  [31:0] sprRdData,
  output reg         sprDone,
  output reg         sprProgExc,
  output reg         sprNoOp,
  // exception entry, return, machine state moves
  input  wire        excTake,
  input  wire [31:0] excAddr,
  input  wire [31:0] excStatus,
  input  wire        rfiEn,
  input  wire        msrWrEn,
  input  wire [31:0] msrWrData,
  output reg  [31:0] machineState,
  output reg         userMode,
  output reg  [31:0] rfiTarget,
  output reg         rfiValid,
  // translation and external control state
  input  wire [1:0]  batSel,
  output reg  [31:0] batUpper,
  output reg  [31:0] batLower,
  output reg  [31:0] pageTableDescriptor,
  output reg  [31:0] externalAccessControl,
  output reg  [3:0]  processorTag
);

  parameter NUM_REGS = 32;

  // ==========================================================
  // storage
  reg [31:0] integerRegs [0:NUM_REGS-1];
  reg [63:0] floatRegs   [0:NUM_REGS-1];
  reg [31:0] saveRestoreFirst;
  reg [31:0] saveRestoreSecond;
  reg [31:0] osScratchRegs [0:3];
  reg [31:0] batUpperRegs  [0:3];
  reg [31:0] batLowerRegs  [0:3];
  integer    k;

  wire [63:0] singleAsDouble;
  wire [31:0] doubleAsSingle;
  wire [63:0] roundedSingle;

  // ==========================================================
  // format conversion
  carf_fp_convert u_conv (
    .memSingle      (fpLoadData[31:0]),
    .regDouble      (floatRegs[fpStoreSel]),
    .arithDouble    (fpWbData),
    .roundMode      (floatStatusControl[1:0]),
    .singleAsDouble (singleAsDouble),
    .doubleAsSingle (doubleAsSingle),
    .roundedSingle  (roundedSingle)
  );

  // ==========================================================
  // special register decode
  reg        next_known;
  reg [31:0] next_rdVal;
  wire       isUser   = machineState[`CARF_MSR_PR_BIT];
  wire       encBit0  = sprNum[`CARF_SPR_ENC_BIT0];
  wire [9:0] ossBase  = `CARF_SPR_OSS_BASE;
  wire [9:0] batBase  = `CARF_SPR_BAT_BASE;
  wire       isOss    = (sprNum[9:2] == ossBase[9:2]);
  wire       isBat    = (sprNum[9:3] == batBase[9:3]);
  wire [1:0] batIdx   = sprNum[2:1];

  // register number lookup for moves
  always @* begin
    next_known = 1'b1;
    next_rdVal = 32'h0000_0000;
    if (isOss) begin
      next_rdVal = osScratchRegs[sprNum[1:0]];
    end else if (isBat) begin
      next_rdVal = sprNum[0] ? batLowerRegs[batIdx]
                             : batUpperRegs[batIdx];
    end else begin
      case (sprNum)
        `CARF_SPR_PTD:       next_rdVal = pageTableDescriptor;
        `CARF_SPR_SRR_FIRST: next_rdVal = saveRestoreFirst;
        `CARF_SPR_SRR_SEC:   next_rdVal = saveRestoreSecond;
        `CARF_SPR_EXT_ACC:   next_rdVal = externalAccessControl;
        `CARF_SPR_VERSION:   next_rdVal = `CARF_VERSION_VAL;
        `CARF_SPR_PROC_TAG:  next_rdVal = {28'h0, processorTag};
        default:             next_known = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // integer file: three reads, one write, cleared by reset
  always @(posedge core_clk) begin
    if (srst) begin
      for (k = 0; k < NUM_REGS; k = k + 1) begin
        integerRegs[k] <= 32'h0000_0000;
      end
      intRdDataA <= 32'h0000_0000;
      intRdDataB <= 32'h0000_0000;
      intRdDataC <= 32'h0000_0000;
    end else begin
      intRdDataA <= integerRegs[intRdSelA];
      intRdDataB <= integerRegs[intRdSelB];
      intRdDataC <= integerRegs[intRdSelC];
      if (sprEn && !sprWrite && !excTake && next_known &&
          !(isUser && encBit0)) begin
        integerRegs[intWrSel] <= next_rdVal;
      end else if (intWrEn) begin
        integerRegs[intWrSel] <= intWrData;
      end
    end
  end

  // ==========================================================
  // float file: reads, arithmetic writeback, loads, stores
  always @(posedge core_clk) begin
    if (srst) begin
      for (k = 0; k < NUM_REGS; k = k + 1) begin
        floatRegs[k] <= 64'h0;
      end
      fpRdDataA    <= 64'h0;
      fpRdDataB    <= 64'h0;
      fpRdDataC    <= 64'h0;
      fpStoreData  <= 64'h0;
      fpStoreValid <= 1'b0;
    end else begin
      fpRdDataA    <= floatRegs[fpRdSelA];
      fpRdDataB    <= floatRegs[fpRdSelB];
      fpRdDataC    <= floatRegs[fpRdSelC];
      fpStoreValid <= fpStoreEn;
      if (fpStoreEn) begin
        fpStoreData <= fpStoreSingle
                       ? {32'h0, doubleAsSingle}
                       : floatRegs[fpStoreSel];
      end
      if (fpLoadEn) begin
        floatRegs[fpLoadSel] <= fpLoadSingle
                                ? singleAsDouble
                                : fpLoadData;
      end else if (fpWbEn) begin
        floatRegs[fpWbSel] <= fpWbSingle
                              ? roundedSingle
                              : fpWbData;
      end
    end
  end

  // ==========================================================
  // float status and condition field, only at final writeback
  always @(posedge core_clk) begin
    if (srst) begin
      floatStatusControl <= `CARF_FSC_RESET;
      fpCondField        <= 4'h0;
    end else if (fpWbEn) begin
      floatStatusControl <= fpWbStatus |
        (floatStatusControl & `CARF_FSC_STICKY);
      if (fpWbCrEn) begin
        fpCondField <= fpWbStatus[31:28];
      end
    end
  end

  // ==========================================================
  // machine state, save/restore, moves to special registers
  always @(posedge core_clk) begin
    if (srst) begin
      machineState          <= `CARF_MSR_RESET;
      userMode              <= 1'b0;
      saveRestoreFirst      <= 32'h0000_0000;
      saveRestoreSecond     <= 32'h0000_0000;
      rfiTarget             <= 32'h0000_0000;
      rfiValid              <= 1'b0;
      pageTableDescriptor   <= 32'h0000_0000;
      externalAccessControl <= 32'h0000_0000;
      processorTag          <= `CARF_PROC_TAG_RST;
      sprRdData             <= 32'h0000_0000;
      sprDone               <= 1'b0;
      sprProgExc            <= 1'b0;
      sprNoOp               <= 1'b0;
      batUpper              <= 32'h0000_0000;
      batLower              <= 32'h0000_0000;
      for (k = 0; k < 4; k = k + 1) begin
        osScratchRegs[k] <= 32'h0000_0000;
        batUpperRegs[k]  <= 32'h0000_0000;
        batLowerRegs[k]  <= 32'h0000_0000;
      end
    end else begin
      rfiValid   <= rfiEn & ~excTake;
      sprDone    <= 1'b0;
      sprProgExc <= 1'b0;
      sprNoOp    <= 1'b0;
      batUpper   <= batUpperRegs[batSel];
      batLower   <= batLowerRegs[batSel];
      userMode   <= machineState[`CARF_MSR_PR_BIT];
      if (excTake) begin
        saveRestoreFirst  <= excAddr;
        saveRestoreSecond <= excStatus;
        machineState[`CARF_MSR_PR_BIT] <= 1'b0;
      end else if (rfiEn) begin
        rfiTarget    <= saveRestoreFirst;
        machineState <= saveRestoreSecond;
      end else if (msrWrEn && !isUser) begin
        machineState <= msrWrData;
      end
      if (sprEn && !excTake) begin
        if (isUser && encBit0) begin
          sprProgExc <= 1'b1;
        end else if (!next_known) begin
          sprProgExc <= encBit0;
          sprNoOp    <= ~encBit0;
        end else begin
          sprDone   <= 1'b1;
          sprRdData <= next_rdVal;
          if (sprWrite) begin
            if (isOss) begin
              osScratchRegs[sprNum[1:0]] <= sprWrData;
            end else if (isBat && sprNum[0]) begin
              batLowerRegs[batIdx] <= sprWrData;
            end else if (isBat) begin
              batUpperRegs[batIdx] <= sprWrData;
            end else begin
              case (sprNum)
                `CARF_SPR_PTD:
                  pageTableDescriptor <= sprWrData;
                `CARF_SPR_SRR_FIRST:
                  saveRestoreFirst <= sprWrData;
                `CARF_SPR_SRR_SEC:
                  saveRestoreSecond <= sprWrData;
                `CARF_SPR_EXT_ACC:
                  externalAccessControl <= sprWrData;
                `CARF_SPR_PROC_TAG:
                  processorTag <= sprWrData[3:0];
                default: ;
              endcase
            end
          end
        end
      end
    end
  end

endmodule // carf_reg_file

// ==== bench/carf_exec_model.sv ====
`timescale 1ns/1ps
// ==========================================================
// memory side of the float store path
module carf_exec_model (
  // clock and reset
  input  wire        core_clk,
  input  wire        srst,
  // store data from the register set
  input  wire        fpStoreValid,
  input  wire [63:0] fpStoreData,
  // last word written to memory
  output reg  [63:0] memWord
);
  // take each store whole, as handed over, with no reshaping
  always @(posedge core_clk) begin
    if (srst) begin
      memWord <= 64'h0;
    end else if (fpStoreValid) begin
      memWord <= fpStoreData;
    end
  end
endmodule // carf_exec_model

// ==== bench/carf_reg_monitor.sv ====
`timescale 1ns/1ps
// ==========================================================
// port-level checks of the register set
module carf_reg_monitor (
  // clock and reset
  input wire        core_clk,
  input wire        srst,
  // file read data
  input wire [31:0] intRdDataA,
  input wire [63:0] fpRdDataA,
  // float writeback and store
  input wire        fpWbEn,
  input wire        fpWbCrEn,
  input wire [31:0] fpWbStatus,
  input wire [31:0] floatStatusControl,
  input wire [3:0]  fpCondField,
  input wire        fpStoreEn,
  input wire        fpStoreValid,
  // special register moves
  input wire        sprEn,
  input wire [9:0]  sprNum,
  input wire        sprDone,
  input wire        sprProgExc,
  input wire        sprNoOp,
  // exceptions and machine state
  input wire        excTake,
  input wire [31:0] excAddr,
  input wire [31:0] excStatus,
  input wire        rfiEn,
  input wire [31:0] rfiTarget,
  input wire        rfiValid,
  input wire [31:0] machineState,
  input wire        userMode
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // files read zero just after reset
  property p_int_clr; $fell(srst) |=> intRdDataA == 32'h0; endproperty
  a_int_clr: assert property (p_int_clr) else $error("int not clear");
  property p_fp_clr; $fell(srst) |=> fpRdDataA == 64'h0; endproperty
  a_fp_clr: assert property (p_fp_clr) else $error("fp not clear");
  // every special move without an exception in the same cycle gets exactly one outcome
  property p_spr_one;
    sprEn && !excTake |=> $onehot({sprDone, sprProgExc, sprNoOp});
  endproperty
  a_spr_one: assert property (p_spr_one) else $error("spr outcome");
  // unknown numbers split on encoding bit 0
  property p_spr_unk;
    sprEn && !excTake && (sprNum == 10'h010 || sprNum == 10'h020)
      |=> sprProgExc == $past(sprNum[4]) && sprNoOp != $past(sprNum[4]);
  endproperty
  a_spr_unk: assert property (p_spr_unk) else $error("spr unknown");
  // user code is refused supervisor numbers
  property p_priv;
    sprEn && !excTake && machineState[14] && sprNum[4] |=> sprProgExc;
  endproperty
  a_priv: assert property (p_priv) else $error("priv refuse");
  // exception entry lands in supervisor mode
  property p_exc_sup; excTake |=> !machineState[14]; endproperty
  a_exc_sup: assert property (p_exc_sup) else $error("exc mode");
  // return straight after entry restores what entry saved
  property p_rfi;
    excTake ##1 (rfiEn && !excTake) |=> rfiValid
      && rfiTarget == $past(excAddr, 2) && machineState == $past(excStatus, 2);
  endproperty
  a_rfi: assert property (p_rfi) else $error("rfi restore");
  // status accumulates sticky bits at writeback only
  property p_fsc;
    fpWbEn |=> floatStatusControl
      == ($past(fpWbStatus) | ($past(floatStatusControl) & 32'hfff80700));
  endproperty
  a_fsc: assert property (p_fsc) else $error("status update");
  property p_cond;
    fpWbEn && fpWbCrEn |=> fpCondField == $past(fpWbStatus[31:28]);
  endproperty
  a_cond: assert property (p_cond) else $error("cond update");
  // store valid follows its request by one cycle
  property p_store; 1 |=> fpStoreValid == $past(fpStoreEn); endproperty
  a_store: assert property (p_store) else $error("store valid");
  // user flag trails the privilege bit by one cycle
  property p_user; 1 |=> userMode == $past(machineState[14]); endproperty
  a_user: assert property (p_user) else $error("user flag");
endmodule // carf_reg_monitor

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`include "carf_consts.vh"
// ==========================================================
// self-checking bench for the register set
module tb_top;
  // clock, counters and scratch values
  logic        core_clk = 0;
  logic        srst = 1;
  int          err_total = 0;
  int          checks = 0;
  int          seed;
  logic [4:0]  ra;
  logic [31:0] rd, sv, fs, ea, es;
  logic [63:0] dv;
  logic [31:0] wv [17];
  logic [9:0]  nums [17] = '{10'h019, 10'h01a, 10'h01b, 10'h110, 10'h111,
    10'h112, 10'h113, 10'h11a, 10'h210, 10'h211, 10'h212, 10'h213,
    10'h214, 10'h215, 10'h216, 10'h217, 10'h3ff};
  // design inputs, idle at time zero
  logic        intWrEn = 0, fpWbEn = 0, fpWbSingle = 0, fpWbCrEn = 0;
  logic        fpLoadEn = 0, fpLoadSingle = 0, fpStoreEn = 0, rfiEn = 0;
  logic        fpStoreSingle = 0, sprEn = 0, sprWrite = 0, excTake = 0;
  logic        msrWrEn = 0;
  logic [1:0]  batSel = 0;
  logic [4:0]  intRdSelA = 0, intRdSelB = 0, intRdSelC = 0, intWrSel = 0;
  logic [4:0]  fpRdSelA = 0, fpRdSelB = 0, fpRdSelC = 0, fpWbSel = 0;
  logic [4:0]  fpLoadSel = 0, fpStoreSel = 0;
  logic [9:0]  sprNum = 0;
  logic [31:0] intWrData = 0, fpWbStatus = 0, sprWrData = 0, excAddr = 0;
  logic [31:0] excStatus = 0, msrWrData = 0;
  logic [63:0] fpWbData = 0, fpLoadData = 0;
  // design outputs and the memory word
  wire [31:0] intRdDataA, intRdDataB, intRdDataC, floatStatusControl;
  wire [31:0] sprRdData, machineState, rfiTarget, batUpper, batLower;
  wire [31:0] pageTableDescriptor, externalAccessControl;
  wire [63:0] fpRdDataA, fpRdDataB, fpRdDataC, fpStoreData, memWord;
  wire [3:0]  fpCondField, processorTag;
  wire        fpStoreValid, sprDone, sprProgExc, sprNoOp, userMode, rfiValid;
  // device and memory side
  carf_reg_file i_dut (.*);
  carf_exec_model i_mem (.*);
  // 50 MHz clock
  always #10 core_clk = ~core_clk;
  // edge, compare, verdict
  task tk;
    @(posedge core_clk);
  endtask
  task chk(input string nm, input logic [63:0] e, input logic [63:0] s);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
  endtask
  task results;
    $display("mismatches %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // normalised single widened to the equal double
  function logic [63:0] s2d(input logic [31:0] f);
    s2d = {f[31], f[30], {3{~f[30]}}, f[29:23], f[22:0], 29'h0};
  endfunction
  // single rounding of a value whose dropped bits hold only the guard bit
  function logic [63:0] rnd(input logic [63:0] d, input logic [1:0] m);
    logic up;
    up = (m == 2'b00) ? d[29] : (m == 2'b10) ? !d[63] : (m == 2'b11) & d[63];
    rnd = {d[63:29] + 35'(up), 29'h0};
  endfunction
  // bus-free transfers, one request per task
  task iwr(input [4:0] r, input [31:0] d);
    tk;
    intWrEn <= 1;
    intWrSel <= r;
    intWrData <= d;
    tk;
    intWrEn <= 0;
  endtask
  task ird(input [4:0] r, input [31:0] e);
    tk;
    {intRdSelA, intRdSelB, intRdSelC} <= {r, r, r};
    tk;
    #1;
    chk("intAB", {e, e}, {intRdDataA, intRdDataB});
    chk("intC", e, intRdDataC);
  endtask
  task fld(input s, input [4:0] r, input [63:0] d);
    tk;
    {fpLoadEn, fpLoadSingle, fpLoadSel, fpLoadData} <= {1'b1, s, r, d};
    tk;
    fpLoadEn <= 0;
  endtask
  task frd(input [4:0] r, input [63:0] e);
    tk;
    {fpRdSelA, fpRdSelB, fpRdSelC} <= {r, r, r};
    tk;
    #1;
    chk("fpA", e, fpRdDataA);
    chk("fpB", e, fpRdDataB);
    chk("fpC", e, fpRdDataC);
  endtask
  task fst(input s, input [4:0] r, input [63:0] e);
    tk;
    {fpStoreEn, fpStoreSingle, fpStoreSel} <= {1'b1, s, r};
    tk;
    fpStoreEn <= 0;
    #1;
    chk("stD", e, fpStoreData);
    chk("stV", 1, fpStoreValid);
    tk;
    #1;
    chk("mem", e, memWord);
  endtask
  task spr(input w, input [9:0] n, input [31:0] d, input [2:0] k,
           input [31:0] e);
    tk;
    {sprEn, sprWrite, sprNum, sprWrData, intWrSel} <= {1'b1, w, n, d, 5'd7};
    tk;
    sprEn <= 0;
    #1;
    chk("sprK", k, {sprDone, sprProgExc, sprNoOp});
    if (!w && k == 3'b100) chk("sprD", e, sprRdData);
  endtask
  task pulse(input x, input r);
    tk;
    {excTake, rfiEn, excAddr, excStatus} <= {x, r, ea, es};
    tk;
    {excTake, rfiEn} <= 2'b00;
    #1;
  endtask
  task msw(input [31:0] d);
    tk;
    {msrWrEn, msrWrData} <= {1'b1, d};
    tk;
    msrWrEn <= 0;
    #1;
  endtask
  // watchdog for a hung run
  initial begin
    #1000000;
    err_total++;
    results;
  end
  // main sequence
  initial begin
    seed = $urandom(23149);
    repeat (4) tk;
    srst <= 0;
    ird(5'($urandom), 32'h0);
    frd(5'($urandom), 64'h0);
    for (int i = 0; i < 8; i++) begin
      ra = (i == 0) ? 5'd0 : (i == 1) ? 5'd31 : 5'($urandom);
      rd = $urandom;
      iwr(ra, rd);
      ird(ra, rd);
    end
    for (int i = 0; i < 5; i++) begin
      ra = 5'($urandom);
      dv = {$urandom, $urandom};
      sv = {1'($urandom), 8'(1 + $urandom % 254), 23'($urandom)};
      fld(0, ra, dv);
      frd(ra, dv);
      fst(0, ra, dv);
      fld(1, ra, {32'h0, sv});
      frd(ra, s2d(sv));
      fst(1, ra, {32'h0, sv});
    end
    // a denormal single, loaded and stored back
    fld(1, 5'd3, 64'h8000_0003);
    frd(5'd3, 64'hb6b8_0000_0000_0000);
    fst(1, 5'd3, 64'h8000_0003);
    // arithmetic writeback of single-exact values with the guard bit set
    fs = 32'h0;
    for (int i = 0; i < 6; i++) begin
      ra = 5'($urandom);
      rd = $urandom;
      sv = {1'($urandom), 8'(1 + $urandom % 254), 23'($urandom)};
      dv = s2d(sv) | 64'h1000_0000; // guard bit set, rounded on single writebacks
      tk;
      {fpWbEn, fpWbSel, fpWbData, fpWbSingle} <= {1'b1, ra, dv, 1'(i)};
      {fpWbStatus, fpWbCrEn} <= {rd, 1'b1};
      tk;
      fpWbEn <= 0;
      #1;
      if (i[0]) dv = rnd(dv, fs[1:0]);
      fs = rd | (fs & `CARF_FSC_STICKY);
      chk("fsc", {fs, rd[31:28]}, {floatStatusControl, fpCondField});
      frd(ra, dv);
    end
    // every writable special register, written then read
    foreach (nums[j]) begin
      wv[j] = $urandom;
      spr(1, nums[j], wv[j], 3'b100, 32'h0);
    end
    foreach (nums[j]) begin
      rd = (j == 16) ? {28'h0, wv[j][3:0]} : wv[j];
      spr(0, nums[j], 32'h0, 3'b100, rd);
    end
    chk("ptd", wv[0], pageTableDescriptor);
    chk("eac", wv[7], externalAccessControl);
    chk("tag", wv[16][3:0], processorTag);
    for (int j = 0; j < 4; j++) begin
      tk;
      batSel <= 2'(j);
      tk;
      #1;
      chk("bat", {wv[8+2*j], wv[9+2*j]}, {batUpper, batLower});
    end
    spr(1, 10'h11f, $urandom, 3'b100, 32'h0);
    spr(0, 10'h11f, 32'h0, 3'b100, `CARF_VERSION_VAL);
    ird(5'd7, `CARF_VERSION_VAL);
    spr(0, 10'h010, 32'h0, 3'b010, 32'h0);
    spr(1, 10'h020, 32'h0, 3'b001, 32'h0);
    // exception entry and return into user mode
    ea = $urandom;
    es = $urandom | 32'h0000_4000; // privilege bit set: return to user
    pulse(1, 0);
    chk("msrSup", 0, machineState[14]);
    spr(0, 10'h01a, 32'h0, 3'b100, ea);
    spr(0, 10'h01b, 32'h0, 3'b100, es);
    pulse(0, 1);
    chk("rfiV", 1, rfiValid);
    chk("rfi", {ea, es}, {rfiTarget, machineState});
    tk;
    #1;
    chk("user", 1, userMode);
    msw(32'h0000_0000);
    chk("msrUsr", es, machineState);
    spr(0, 10'h110, 32'h0, 3'b010, 32'h0);
    spr(0, 10'h020, 32'h0, 3'b001, 32'h0);
    pulse(1, 0);
    chk("msrSup2", 0, machineState[14]);
    msw(ea & 32'hffff_bfff);
    chk("msrW", ea & 32'hffff_bfff, machineState);
    spr(0, 10'h110, 32'h0, 3'b100, wv[3]);
    // return in the cycle straight after entry
    ea = ~ea;
    es = ~es | 32'h0000_4000;
    tk;
    {excTake, excAddr, excStatus} <= {1'b1, ea, es};
    tk;
    {excTake, rfiEn} <= 2'b01;
    tk;
    rfiEn <= 0;
    #1;
    chk("rfiV2", 1, rfiValid);
    chk("rfi2", {ea, es}, {rfiTarget, machineState});
    // second reset in mid-run
    tk;
    srst <= 1;
    tk;
    srst <= 0;
    ird(ra, 32'h0);
    frd(ra, 64'h0);
    chk("fscRst", 0, floatStatusControl);
    chk("msrRst", 0, machineState);
    results;
  end
endmodule // tb_top
bind carf_reg_file carf_reg_monitor i_mon (.*);
